// >>> common/pweb_pkg.sv
// Constants shared by the wake enable bank and its bus front end.
`default_nettype none
package pweb_pkg;
  // Register indices; byte address is four times the index.
  localparam int          IDX_W         = 8;
  localparam int          ADDR_LSB      = 2;
  localparam logic [7:0]  IDX_WAKE_EN3  = 8'h0c;
  localparam logic [7:0]  IDX_WAKE_EN4  = 8'h0d;
  localparam logic [7:0]  IDX_WAKE_EN5  = 8'h0e;
  localparam logic [7:0]  IDX_RSVD      = 8'h0f;
  localparam logic [7:0]  IDX_WAKE_STS3 = 8'h20;
  localparam logic [7:0]  IDX_WAKE_STS4 = 8'h21;
  localparam logic [7:0]  IDX_WAKE_STS5 = 8'h22;
  localparam logic [7:0]  IDX_CTRL      = 8'h23;
  localparam logic [7:0]  IDX_IRQ_STS   = 8'h24;
  localparam logic [7:0]  IDX_IRQ_MASK  = 8'h25;
  // Values after the standby-supply reset.
  localparam logic [7:0]  WAKE_EN_RST   = 8'h00;
  localparam logic [7:0]  WAKE_STS_RST  = 8'h00;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [1:0]  IRQ_RST       = 2'h0;
  // Field positions.
  localparam int          CTRL_GLOBAL_BIT = 0;
  localparam int          GROUP_SMI_BIT   = 3;
  localparam int          IRQ_W           = 2;
  localparam int          IRQ_STS_SET_BIT = 0;
  localparam int          IRQ_WAKE_BIT    = 1;
  localparam int          NUM_BANKS       = 3;
  localparam logic [31:0] HRDATA_ZERO     = 32'h0000_0000;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;
endpackage : pweb_pkg
`default_nettype wire

// >>> hdl/pweb_ahb.sv
// AHB-Lite slave front end for the wake enable bank registers.
`timescale 1ns/1ps
`default_nettype none
module pweb_ahb
(
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      host_reset,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output var logic [31:0]                hrdata,
  output logic                           wr_en,
  output logic [pweb_pkg::IDX_W-1:0]     wr_idx,
  output logic [7:0]                     wr_data,
  output logic                           rd_en,
  output logic [pweb_pkg::IDX_W-1:0]     rd_idx,
  input  wire logic [7:0]                rd_data
);
  import pweb_pkg::*;

  logic                 dwrite_r;
  logic                 rd_wait_r;
  logic [IDX_W-1:0]     didx_r;
  logic                 accept;
  logic                 size_unused;

  ////////////////////////////////////////////////////////////////////////////
  // Address phase capture.

  // Only whole-word transfers are expected, so the size is not decoded.
  assign size_unused = |hsize;
  assign accept      = hsel && htrans[1] && hready;

  // Latch the decoded index and direction of an accepted transfer.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dwrite_r <= 1'b0;
      didx_r   <= '0;
    end
    else if (host_reset)
    begin
      dwrite_r <= 1'b0;
    end
    else if (accept)
    begin
      dwrite_r <= hwrite;
      didx_r   <= haddr[ADDR_LSB +: IDX_W];
    end
    else if (hready)
    begin
      dwrite_r <= 1'b0;
    end
  end

  // A read spends one wait state so the data leave a flip-flop.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_wait_r <= 1'b0;
    else if (host_reset)
      rd_wait_r <= 1'b0;
    else
      rd_wait_r <= accept && !hwrite;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data phase.

  // Read data are captured at the end of the wait state.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata <= HRDATA_ZERO;
    else if (rd_wait_r)
      hrdata <= {24'h00_0000, rd_data};
  end

  // Writes complete with no wait; every answer is OKAY.
  assign wr_en     = dwrite_r;
  assign wr_idx    = didx_r;
  assign wr_data   = hwdata[7:0];
  assign rd_en     = rd_wait_r;
  assign rd_idx    = didx_r;
  assign hreadyout = !rd_wait_r;
  assign hresp     = 1'b0 & size_unused;
endmodule : pweb_ahb
`default_nettype wire

// >>> hdl/pweb_byte.sv
// One wake bank byte: enable register and sticky wake status register.
`timescale 1ns/1ps
`default_nettype none
module pweb_byte
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       en_we,
  input  wire logic       sts_we,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] event_in,
  output var logic  [7:0] enable,
  output var logic  [7:0] status,
  output logic            new_set
);
  import pweb_pkg::*;

  logic [7:0] sts_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Enable register, cleared only by the standby-supply reset.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      enable <= WAKE_EN_RST; // RULE7
    else if (en_we)
      enable <= wdata; // RULE12
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status: events set bits whatever the enables; a written one clears.
  always_comb
  begin
    sts_nxt = status;
    if (sts_we)
      sts_nxt = sts_nxt & ~wdata; // RULE10
    sts_nxt = sts_nxt | event_in; // RULE9
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status <= WAKE_STS_RST;
    else
      status <= sts_nxt;
  end

  // Flags an event that sets a status bit not yet set.
  assign new_set = |(event_in & ~status);
endmodule : pweb_byte
`default_nettype wire

// >>> hdl/pweb_top.sv
// Wake enable bank: enables, wake status, wake output and register slave.
//
// Function
// RULE1: Wake output asserts for a source only if enable, status and global enable are set.
// RULE2: A disabled source still records status but never drives the wake output.
// RULE3: Third enable bits 0,1,2,4,5,6,7 gate gpio_2_0..2, gpio_2_4..7.
// RULE4: Third enable bit 3 lets the group SMI event act as a wake source.
// RULE5: Fourth enable bits gate gpio_3_0..3, gpio_4_1, gpio_4_3, gpio_6_0, gpio_6_1.
// RULE6: Fifth enable bits 0..7 gate gpio_5_0 through gpio_5_7.
// RULE7: Enables survive main, soft and hard resets; only standby reset clears them.
// RULE8: The reserved location after the fifth enable always reads zero.
// RULE9: A status bit sets on its source event regardless of any enable.
// RULE10: Writing one clears a status bit; writing zero leaves it.
// RULE11: Wake output is active-low OR of enabled pending sources, gated globally.
// RULE12: Enable registers are fully read/write and read back the last write.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pweb_top
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        host_reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        gpio_2_0,
  input  wire logic        gpio_2_1,
  input  wire logic        gpio_2_2,
  input  wire logic        group_smi_event,
  input  wire logic        gpio_2_4,
  input  wire logic        gpio_2_5,
  input  wire logic        gpio_2_6,
  input  wire logic        gpio_2_7,
  input  wire logic        gpio_3_0,
  input  wire logic        gpio_3_1,
  input  wire logic        gpio_3_2,
  input  wire logic        gpio_3_3,
  input  wire logic        gpio_4_1,
  input  wire logic        gpio_4_3,
  input  wire logic        gpio_6_0,
  input  wire logic        gpio_6_1,
  input  wire logic        gpio_5_0,
  input  wire logic        gpio_5_1,
  input  wire logic        gpio_5_2,
  input  wire logic        gpio_5_3,
  input  wire logic        gpio_5_4,
  input  wire logic        gpio_5_5,
  input  wire logic        gpio_5_6,
  input  wire logic        gpio_5_7,
  output var logic         wake_out_n,
  output logic             irq
);
  import pweb_pkg::*;

  logic                  wr_en;
  logic [IDX_W-1:0]      wr_idx;
  logic [7:0]            wr_data;
  logic                  rd_en;
  logic [IDX_W-1:0]      rd_idx;
  logic [7:0]            rd_data;
  logic [7:0]            ev    [NUM_BANKS];
  logic [7:0]            en    [NUM_BANKS];
  logic [7:0]            sts   [NUM_BANKS];
  logic [NUM_BANKS-1:0]  nset;
  logic [NUM_BANKS-1:0]  pend;
  logic [7:0]            ctrl_r;
  logic                  global_wake_enable;
  logic                  wake_pending;
  logic                  pending_r;
  logic [IRQ_W-1:0]      irq_sts_r;
  logic [IRQ_W-1:0]      irq_mask_r;
  logic [IRQ_W-1:0]      irq_ev;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end.
  pweb_ahb u_ahb
  (
    .clk        (clk),
    .rst_n      (rst_n),
    .host_reset (host_reset),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hsize      (hsize),
    .hwdata     (hwdata),
    .hready     (hready),
    .hreadyout  (hreadyout),
    .hresp      (hresp),
    .hrdata     (hrdata),
    .wr_en      (wr_en),
    .wr_idx     (wr_idx),
    .wr_data    (wr_data),
    .rd_en      (rd_en),
    .rd_idx     (rd_idx),
    .rd_data    (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wake source to bit mapping; bit 3 of the first bank is the group SMI.
  assign ev[0] = {gpio_2_7, gpio_2_6, gpio_2_5, gpio_2_4, group_smi_event,
                  gpio_2_2, gpio_2_1, gpio_2_0}; // RULE3 RULE4
  assign ev[1] = {gpio_6_1, gpio_6_0, gpio_4_3, gpio_4_1, gpio_3_3,
                  gpio_3_2, gpio_3_1, gpio_3_0}; // RULE5
  assign ev[2] = {gpio_5_7, gpio_5_6, gpio_5_5, gpio_5_4, gpio_5_3,
                  gpio_5_2, gpio_5_1, gpio_5_0}; // RULE6

  // One enable and status byte per bank.
  generate
    for (genvar b = 0; b < NUM_BANKS; b++)
    begin : g_bank
      pweb_byte u_byte
      (
        .clk      (clk),
        .rst_n    (rst_n),
        .en_we    (wr_en && (wr_idx == IDX_WAKE_EN3 + 8'(b))),
        .sts_we   (wr_en && (wr_idx == IDX_WAKE_STS3 + 8'(b))),
        .wdata    (wr_data),
        .event_in (ev[b]),
        .enable   (en[b]),
        .status   (sts[b]),
        .new_set  (nset[b])
      );
      assign pend[b] = |(sts[b] & en[b]); // RULE1 RULE2
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Global wake enable and the registered wake output.

  // Control register; bit 0 is the global wake enable.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_r <= CTRL_RST;
    else if (wr_en && (wr_idx == IDX_CTRL))
      ctrl_r <= {7'h00, wr_data[CTRL_GLOBAL_BIT]};
  end

  // The global enable gates every pending source into one wake request.
  assign global_wake_enable = ctrl_r[CTRL_GLOBAL_BIT];
  assign wake_pending       = global_wake_enable && (|pend); // RULE11

  // Output is driven low one cycle after a gated pending source appears.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_out_n <= 1'b1;
      pending_r  <= 1'b0;
    end
    else
    begin
      wake_out_n <= !wake_pending; // RULE1 RULE11
      pending_r  <= wake_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and output.
  assign irq_ev[IRQ_STS_SET_BIT] = |nset;
  assign irq_ev[IRQ_WAKE_BIT]    = wake_pending && !pending_r;

  // Sticky bits: a written one clears, a new event wins over the clear.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_sts_r <= IRQ_RST;
    else if (wr_en && (wr_idx == IDX_IRQ_STS))
      irq_sts_r <= (irq_sts_r & ~wr_data[IRQ_W-1:0]) | irq_ev;
    else
      irq_sts_r <= irq_sts_r | irq_ev;
  end

  // Interrupt mask, same bit layout as the interrupt status.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask_r <= IRQ_RST;
    else if (wr_en && (wr_idx == IDX_IRQ_MASK))
      irq_mask_r <= wr_data[IRQ_W-1:0];
  end

  // Level interrupt while any unmasked status bit stays set.
  assign irq = |(irq_sts_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; reserved and unmapped locations read zero.
  always_comb
  begin
    unique case (rd_idx)
      IDX_WAKE_EN3:  rd_data = en[0]; // RULE12
      IDX_WAKE_EN4:  rd_data = en[1];
      IDX_WAKE_EN5:  rd_data = en[2];
      IDX_RSVD:      rd_data = BYTE_ZERO; // RULE8
      IDX_WAKE_STS3: rd_data = sts[0];
      IDX_WAKE_STS4: rd_data = sts[1];
      IDX_WAKE_STS5: rd_data = sts[2];
      IDX_CTRL:      rd_data = ctrl_r;
      IDX_IRQ_STS:   rd_data = {6'h00, irq_sts_r};
      IDX_IRQ_MASK:  rd_data = {6'h00, irq_mask_r};
      default:       rd_data = BYTE_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // The output only falls for a globally enabled, enabled and pending source.
  wake_gate_a: assert property ($fell(wake_out_n) |-> $past(global_wake_enable) // RULE1
    && |$past(pend)) else $error("wake output low without enabled pending source");

  // With the global enable clear nothing may pull the output low.
  global_off_a: assert property (!global_wake_enable |=> wake_out_n) // RULE1
    else $error("wake output low with global enable clear");

  // Pending sources whose enables are clear leave the output high.
  wake_masked_a: assert property ((global_wake_enable && !(|pend)) |=> wake_out_n) // RULE2
    else $error("wake output driven by disabled source");

  // A gated pending source pulls the output low on the next edge.
  wake_or_a: assert property (wake_pending |=> !wake_out_n) // RULE11
    else $error("wake output not asserted for pending source");

  // The top bit of the first bank follows gpio_2_7.
  gpio27_map_a: assert property (gpio_2_7 |=> sts[0][7]) // RULE3
    else $error("gpio_2_7 did not set status bit 7");

  // The group SMI event wakes two edges later unless its enables change under it.
  group_smi_a: assert property ((group_smi_event && en[0][GROUP_SMI_BIT] // RULE4
    && global_wake_enable && !(wr_en && (wr_idx == IDX_CTRL || wr_idx == IDX_WAKE_EN3)))
    |-> ##2 !wake_out_n) else $error("group SMI event did not wake");

  // The top bit of the second bank follows gpio_6_1.
  gpio61_map_a: assert property (gpio_6_1 |=> sts[1][7]) // RULE5
    else $error("gpio_6_1 did not set status bit 7");

  // The bottom bit of the third bank follows gpio_5_0.
  gpio50_map_a: assert property (gpio_5_0 |=> sts[2][0]) // RULE6
    else $error("gpio_5_0 did not set status bit 0");

  // Per source: its event sets its own status bit, and once enabled it wakes.
  for (genvar gb = 0; gb < NUM_BANKS; gb++)
  begin : g_src_chk
    for (genvar gi = 0; gi < 8; gi++)
    begin : g_bit
      sts_bit_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
        ev[gb][gi] |=> sts[gb][gi]) else $error("wake event did not set its status bit");
      src_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
        (global_wake_enable && en[gb][gi] && sts[gb][gi]) |=> !wake_out_n)
        else $error("enabled pending source did not drive the wake output");
    end
  end

  // Enables move only on a write to one of their indices.
  en_hold_a: assert property (!(wr_en && wr_idx >= IDX_WAKE_EN3 // RULE7
    && wr_idx <= IDX_WAKE_EN5) |=> ($stable(en[0]) && $stable(en[1]) && $stable(en[2])))
    else $error("enable changed without a write");

  // A host reset alone leaves the enables, control and mask untouched.
  host_hold_a: assert property ((host_reset && !wr_en) |=> ($stable(en[0]) // RULE7
    && $stable(en[1]) && $stable(en[2]) && $stable(ctrl_r) && $stable(irq_mask_r)))
    else $error("host reset disturbed a register");

  // The reserved location always reads back as zero.
  rsvd_zero_a: assert property ((rd_en && rd_idx == IDX_RSVD) |=> hrdata == HRDATA_ZERO) // RULE8
    else $error("reserved location read nonzero");

  // Every event of the third bank lands in its status byte.
  sts_set_a: assert property ((ev[2] != 8'h00) |=> ((sts[2] & $past(ev[2])) // RULE9
    == $past(ev[2]))) else $error("status missed an event");

  // Writing ones clears status bits and writing zeros keeps them.
  sts_clear_a: assert property ((wr_en && wr_idx == IDX_WAKE_STS4 && ev[1] == 8'h00) // RULE10
    |=> (sts[1] == ($past(sts[1]) & ~$past(wr_data))))
    else $error("status write-one-clear wrong");

  // An enable takes every bit of the written byte.
  en_wr_a: assert property ((wr_en && wr_idx == IDX_WAKE_EN4) // RULE12
    |=> en[1] == $past(wr_data)) else $error("enable did not take written value");

  // A read spends exactly one wait state; every other phase is ready.
  rd_start_a: assert property ((hsel && htrans[1] && hready && !hwrite && !host_reset)
    |=> !hreadyout) else $error("read did not insert its wait state");
  rd_wait_a: assert property (!hreadyout |=> hreadyout)
    else $error("read wait state lasted more than one cycle");

  // New status events and a rising wake request set interrupt bits.
  irq_set_a: assert property ((|nset) |=> irq_sts_r[IRQ_STS_SET_BIT])
    else $error("interrupt status missed a new status event");
  irq_wake_a: assert property ((wake_pending && !pending_r) |=> irq_sts_r[IRQ_WAKE_BIT])
    else $error("interrupt status missed a rising wake request");

  // Writing ones clears interrupt status bits when no event competes.
  irq_clear_a: assert property ((wr_en && wr_idx == IDX_IRQ_STS && irq_ev == 2'h0)
    |=> irq_sts_r == ($past(irq_sts_r) & ~IRQ_W'($past(wr_data))))
    else $error("interrupt status write-one-clear wrong");

  // Main scenarios that the tests are expected to reach.
  wake_seen_c:  cover property ($fell(wake_out_n));
  en_read_c:    cover property (rd_en && rd_idx == IDX_WAKE_EN5);
  sts_clear_c:  cover property (wr_en && wr_idx == IDX_WAKE_STS3 && wr_data != 8'h00);
  irq_seen_c:   cover property ($rose(irq));
  smi_wake_c:   cover property (group_smi_event && en[0][GROUP_SMI_BIT] && global_wake_enable);
endmodule : pweb_top
`default_nettype wire

// >>> testbench/pweb_wake_enable_bank_tb.sv
// Self-checking bench for the wake enable bank over its register bus.
`timescale 1ns/1ps
`default_nettype none
module pweb_wake_enable_bank_tb;
  import pweb_pkg::*;
  logic        clk, rst_n, host_reset, hsel, hwrite, hready, hreadyout, hresp;
  logic        wake_out_n, irq, en;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [23:0] src;
  logic [7:0]  wake_count, pat;
  logic [7:0]  tbl [3] = '{8'ha5, 8'h5a, 8'hc3};
  logic [7:0]  zidx [10] = '{IDX_WAKE_EN3, IDX_WAKE_EN4, IDX_WAKE_EN5, IDX_RSVD,
    IDX_WAKE_STS3, IDX_WAKE_STS4, IDX_WAKE_STS5, IDX_CTRL, IDX_IRQ_STS, IDX_IRQ_MASK};
  int          n_errors, samples_checked, i, j, b, k;

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;

  pweb_top dut (.clk(clk), .rst_n(rst_n), .host_reset(host_reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .gpio_2_0(src[0]), .gpio_2_1(src[1]), .gpio_2_2(src[2]), .group_smi_event(src[3]),
    .gpio_2_4(src[4]), .gpio_2_5(src[5]), .gpio_2_6(src[6]), .gpio_2_7(src[7]),
    .gpio_3_0(src[8]), .gpio_3_1(src[9]), .gpio_3_2(src[10]), .gpio_3_3(src[11]),
    .gpio_4_1(src[12]), .gpio_4_3(src[13]), .gpio_6_0(src[14]), .gpio_6_1(src[15]),
    .gpio_5_0(src[16]), .gpio_5_1(src[17]), .gpio_5_2(src[18]), .gpio_5_3(src[19]),
    .gpio_5_4(src[20]), .gpio_5_5(src[21]), .gpio_5_6(src[22]), .gpio_5_7(src[23]),
    .wake_out_n(wake_out_n), .irq(irq));

  pweb_wake_sink sink (.clk(clk), .rst_n(rst_n), .wake_n(wake_out_n),
    .wake_count(wake_count));

  // Free-running 40 MHz clock.
  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the comparison.
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One single-word transfer; the address phase is held until ready is seen high.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {22'h0, idx, 2'b00};
    @(posedge clk iff hreadyout === 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'hff_ffff, d};
    @(posedge clk iff hreadyout === 1'b1);
    r = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : bus

  // Register write; upper data bits carry ones that must be ignored.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask : wr

  // Register read compared with the expected byte, upper bits zero.
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, idx, 8'h00, r);
    chk("hrdata", r, {24'h0, e});
  endtask : rdc

  // Pulses a set of wake sources for one cycle and lets the output settle.
  task automatic pulse(input logic [23:0] s);
    @(posedge clk);
    src <= s;
    @(posedge clk);
    src <= '0;
    repeat (3) @(posedge clk);
    #1;
  endtask : pulse

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end

  // Main test sequence.
  initial
  begin
    clk = 0; rst_n = 0; host_reset = 0; hsel = 0; hwrite = 0; haddr = '0;
    htrans = 2'b00; hsize = 3'b010; hwdata = '0; src = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (zidx[j]) rdc(zidx[j], 8'h00);
    chk("wake_out_n", {31'h0, wake_out_n}, 32'h1);
    for (j = 0; j < 3; j++) wr(8'(IDX_WAKE_EN3 + j), tbl[j]);
    wr(IDX_RSVD, 8'hff);
    wr(8'h3f, 8'hff);
    for (j = 0; j < 3; j++) rdc(8'(IDX_WAKE_EN3 + j), tbl[j]);
    rdc(IDX_RSVD, 8'h00);
    rdc(8'h3f, 8'h00);
    // A host reset must leave every enable untouched.
    @(posedge clk);
    host_reset <= 1'b1;
    @(posedge clk);
    host_reset <= 1'b0;
    for (j = 0; j < 3; j++) rdc(8'(IDX_WAKE_EN3 + j), tbl[j]);
    // Each source alone enabled, then each source alone disabled.
    wr(IDX_CTRL, 8'h01);
    for (i = 0; i < 48; i++)
    begin
      b = (i % 24) / 8;
      k = i % 8;
      en = (i < 24);
      pat = en ? 8'(1 << k) : ~8'(1 << k);
      for (j = 0; j < 3; j++) wr(8'(IDX_WAKE_EN3 + j), j == b ? pat : {8{~en}});
      pulse(24'(1) << (i % 24));
      chk("wake_out_n", {31'h0, wake_out_n}, {31'h0, ~en});
      rdc(8'(IDX_WAKE_STS3 + b), 8'(1 << k));
      wr(8'(IDX_WAKE_STS3 + b), ~8'(1 << k));
      rdc(8'(IDX_WAKE_STS3 + b), 8'(1 << k));
      wr(8'(IDX_WAKE_STS3 + b), 8'(1 << k));
      rdc(8'(IDX_WAKE_STS3 + b), 8'h00);
      chk("wake_out_n", {31'h0, wake_out_n}, 32'h1);
    end
    chk("wake_count", {24'h0, wake_count}, 32'd24);
    // Global enable off holds the output high until it is set again.
    wr(IDX_CTRL, 8'h00);
    for (j = 0; j < 3; j++) wr(8'(IDX_WAKE_EN3 + j), 8'hff);
    pulse('1);
    chk("wake_out_n", {31'h0, wake_out_n}, 32'h1);
    for (j = 0; j < 3; j++) rdc(8'(IDX_WAKE_STS3 + j), 8'hff);
    wr(IDX_CTRL, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk("wake_out_n", {31'h0, wake_out_n}, 32'h0);
    for (j = 0; j < 3; j++) wr(8'(IDX_WAKE_STS3 + j), 8'hff);
    rdc(IDX_CTRL, 8'h01);
    chk("wake_out_n", {31'h0, wake_out_n}, 32'h1);
    // Interrupt raised, masked and cleared.
    wr(IDX_IRQ_STS, 8'h03);
    wr(IDX_IRQ_MASK, 8'h01);
    pulse(24'h00_0001);
    chk("irq", {31'h0, irq}, 32'h1);
    rdc(IDX_IRQ_STS, 8'h03);
    wr(IDX_IRQ_STS, 8'h01);
    #1;
    chk("irq", {31'h0, irq}, 32'h0);
    wr(IDX_IRQ_MASK, 8'h02);
    #1;
    chk("irq", {31'h0, irq}, 32'h1);
    wr(IDX_IRQ_STS, 8'h02);
    #1;
    chk("irq", {31'h0, irq}, 32'h0);
    // Standby reset in mid-run clears the enables.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("wake_out_n", {31'h0, wake_out_n}, 32'h1);
    for (j = 0; j < 3; j++) rdc(8'(IDX_WAKE_EN3 + j), 8'h00);
    final_report();
  end
endmodule : pweb_wake_enable_bank_tb
`default_nettype wire

// >>> testbench/pweb_wake_sink.sv
// Chipset-side model that receives the active-low wake request line.
`timescale 1ns/1ps
`default_nettype none
module pweb_wake_sink
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wake_n,
  output logic [7:0]      wake_count
);
  logic wake_d_r;

  // Counts each new wake request as a fall of the line, as a chipset edge detector would.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_d_r   <= 1'b1;
      wake_count <= 8'h00;
    end
    else
    begin
      wake_d_r <= wake_n;
      if (wake_d_r && !wake_n)
        wake_count <= wake_count + 8'h01;
    end
  end
endmodule : pweb_wake_sink
`default_nettype wire
